// ===== rtl/ilm_pkg.sv
package ilm_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

  // Trigger slots
  localparam int SLOTS = 5;
  localparam int SEL_W = 4;
  localparam int NUM_SIG = (1 << SEL_W) - 1;

  // Register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_HELD = 8'h0C;
  localparam logic [7:0] OFS_LAMP_BASE = 8'h10;
  localparam int LAMP_STRIDE_LOG2 = 3;
  localparam logic [2:0] OFS_LAMP_TRIG = 3'h0;
  localparam logic [2:0] OFS_LAMP_COL = 3'h4;

  // Field positions
  localparam int CTRL_REMOTE_EN_BIT = 0;
  localparam int CMD_LINK_ACK_BIT = 0;
  localparam int TRIG_SEL_LSB = 0;
  localparam int TRIG_INV_LSB = 20;
  localparam int TRIG_MODE_LSB = 25;
  localparam int COL_ON_LSB = 0;
  localparam int COL_OFF_LSB = 4;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TRIG_RST = 32'h0000_0000;
  localparam logic [31:0] COL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ILM_HOLD_OFF = 2'h0,
    ILM_HOLD_ON = 2'h1,
    ILM_HOLD_ALARM = 2'h2
  } ilm_hold_t;

  typedef enum logic [2:0] {
    ILM_COL_NONE = 3'h0,
    ILM_COL_GREEN = 3'h1,
    ILM_COL_RED = 3'h2,
    ILM_COL_RED_FLASH = 3'h3,
    ILM_COL_GREEN_FLASH = 3'h4
  } ilm_colour_t;

  typedef enum logic [1:0] {
    ILM_HS_BOOT = 2'b01,
    ILM_HS_RUN = 2'b10
  } ilm_health_t;

  // Returns {red, green} for a colour code and the shared flash phase
  function automatic logic [1:0] ilm_colour_drive(input logic [2:0] code, input logic phase);
    logic [1:0] rg;
    rg = 2'h0;
    case (code)
      ILM_COL_GREEN: rg = 2'b01;
      ILM_COL_RED: rg = 2'b10;
      ILM_COL_RED_FLASH: rg = {phase, 1'b0};
      ILM_COL_GREEN_FLASH: rg = {1'b0, phase};
      default: rg = 2'h0;
    endcase
    return rg;
  endfunction

endpackage

// ===== rtl/ilm_cfg_if.sv
`timescale 1ns/1ps
interface ilm_cfg_if;
  logic [ilm_pkg::SLOTS*ilm_pkg::SEL_W-1:0] sel;
  logic [ilm_pkg::SLOTS-1:0] inv;
  ilm_pkg::ilm_hold_t mode;

  modport regs (output sel, output inv, output mode);
  modport lamp (input sel, input inv, input mode);
endinterface

// ===== rtl/ilm_flash_gen.sv
`timescale 1ns/1ps
module ilm_flash_gen #(
  parameter int unsigned HALF_CYC = ilm_pkg::FLASH_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic phase
);
  logic [31:0] cnt_q, cnt_d;
  logic phase_q, phase_d;

  // One divider for every lamp keeps all flashing in one phase
  always_comb begin
    cnt_d = cnt_q + 32'h1;
    phase_d = phase_q;
    if (cnt_q >= HALF_CYC - 1) begin
      cnt_d = 32'h0;
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
endmodule

// ===== rtl/ilm_lamp_cell.sv
`timescale 1ns/1ps
module ilm_lamp_cell (
  input wire logic pclk,
  input wire logic por_n,
  input wire logic [ilm_pkg::NUM_SIG-1:0] sig,
  ilm_cfg_if.lamp cfg,
  input wire logic own_clear,
  input wire logic panel_ack,
  input wire logic remote_ack,
  input wire logic alarm_ack,
  output logic active,
  output logic held
);
  logic held_q, held_d;
  logic trig;
  logic any_assigned;
  logic hold_en;
  logic clear_cause;
  logic [ilm_pkg::SEL_W-1:0] s;

  always_comb begin
    trig = 1'b0;
    any_assigned = 1'b0;
    s = '0;
    for (int i = 0; i < ilm_pkg::SLOTS; i++) begin
      s = cfg.sel[i*ilm_pkg::SEL_W +: ilm_pkg::SEL_W];
      if (s != '0) begin
        any_assigned = 1'b1;
        trig = trig | (sig[s - 4'h1] ^ cfg.inv[i]);
      end
    end
  end

  always_comb begin
    hold_en = (cfg.mode == ilm_pkg::ILM_HOLD_ON) || (cfg.mode == ilm_pkg::ILM_HOLD_ALARM);
    clear_cause = panel_ack | remote_ack | (own_clear & hold_en)
      | (alarm_ack & (cfg.mode == ilm_pkg::ILM_HOLD_ALARM));
    held_d = held_q;
    if (!hold_en || !any_assigned) begin
      held_d = 1'b0;
    end else if (trig) begin
      held_d = 1'b1;
    end else if (clear_cause) begin
      held_d = 1'b0;
    end
  end

  // Held state sits on the power-on reset so restarts do not lose it
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      held_q <= 1'b0;
    end else begin
      held_q <= held_d;
    end
  end

  assign active = hold_en ? (held_q | trig) : trig;
  assign held = held_q;
endmodule

// ===== rtl/ilm_lamp_top.sv
`timescale 1ns/1ps
module ilm_lamp_top #(
  parameter int NUM_LAMPS = 8,
  parameter int unsigned FLASH_HALF_CYC = ilm_pkg::FLASH_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ilm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ilm_pkg::NUM_SIG-1:0] prot_sig,
  input wire logic [NUM_LAMPS-1:0] lamp_clear_in,
  input wire logic global_lamp_clear_input,
  input wire logic prot_alarm,
  input wire logic boot_done,
  input wire logic panel_clear_key,
  output logic [NUM_LAMPS-1:0] lamp_red,
  output logic [NUM_LAMPS-1:0] lamp_green,
  output logic health_green
);

  // Bus handshake state
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // Configuration, kept on the power-on reset together with the held states; link_ack_q is on the bus reset
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] trig_q [NUM_LAMPS];
  logic [31:0] trig_d [NUM_LAMPS];
  logic [31:0] col_q [NUM_LAMPS];
  logic [31:0] col_d [NUM_LAMPS];
  logic link_ack_q, link_ack_d;

  // Panel key synchroniser and edge, alarm edge and remote acknowledgment
  logic key_s1_q, key_s2_q, key_s3_q;
  logic key_s1_d, key_s2_d, key_s3_d;
  logic panel_ack;
  logic alarm_prev_q, alarm_prev_d;
  logic alarm_ack;
  logic remote_ack;

  // Lamp results
  logic [NUM_LAMPS-1:0] active;
  logic [NUM_LAMPS-1:0] held;
  logic phase;
  logic [NUM_LAMPS-1:0] red_q, red_d;
  logic [NUM_LAMPS-1:0] green_q, green_d;
  ilm_pkg::ilm_health_t hs_q, hs_d;
  logic health_q, health_d;

  // Address decode
  logic acc_phase;
  logic wr_fire;
  logic in_lamp;
  logic [ilm_pkg::ADDR_W-1:0] lamp_ofs;
  int unsigned lamp_idx;
  logic [2:0] lamp_sub;
  logic mapped;

  // Register hits
  logic hit_ctrl;
  logic hit_cmd;
  logic hit_status;
  logic hit_held;
  logic hit_trig;
  logic hit_col;

  // Bits that the control, trigger and colour words store
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam logic [31:0] TRIG_MASK = 32'h07FF_FFFF;
  localparam logic [31:0] COL_MASK = 32'h0000_0077;

  always_comb begin
    acc_phase = psel & penable;
    wr_fire = acc_phase & pwrite & pready_q;
    lamp_ofs = paddr - ilm_pkg::OFS_LAMP_BASE;
    lamp_idx = 32'(lamp_ofs >> ilm_pkg::LAMP_STRIDE_LOG2);
    lamp_sub = lamp_ofs[2:0];
    // Lamp i owns the trigger and colour words at base plus eight times i
    hit_trig = (paddr >= ilm_pkg::OFS_LAMP_BASE) && (lamp_idx < NUM_LAMPS) && (lamp_sub == ilm_pkg::OFS_LAMP_TRIG);
    hit_col = (paddr >= ilm_pkg::OFS_LAMP_BASE) && (lamp_idx < NUM_LAMPS) && (lamp_sub == ilm_pkg::OFS_LAMP_COL);
    in_lamp = hit_trig || hit_col;
    hit_ctrl = (paddr == ilm_pkg::OFS_CTRL);
    hit_cmd = (paddr == ilm_pkg::OFS_CMD);
    hit_status = (paddr == ilm_pkg::OFS_STATUS);
    hit_held = (paddr == ilm_pkg::OFS_HELD);
    mapped = in_lamp || hit_ctrl || hit_cmd || hit_status || hit_held;
  end

  // One wait state: answer in the second access cycle
  always_comb begin
    pready_d = acc_phase & ~pready_q;
    pslverr_d = acc_phase & ~pready_q & ~mapped;
    prdata_d = 32'h0000_0000;
    if (acc_phase && !pready_q && !pwrite && mapped) begin
      if (in_lamp) begin
        prdata_d = hit_trig ? trig_q[lamp_idx] : col_q[lamp_idx];
      end else begin
        unique case (paddr)
          ilm_pkg::OFS_CTRL: prdata_d = ctrl_q;
          ilm_pkg::OFS_STATUS: prdata_d = 32'(active);
          ilm_pkg::OFS_HELD: prdata_d = 32'(held);
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Register writes; only the implemented fields are stored
  always_comb begin
    ctrl_d = ctrl_q;
    link_ack_d = 1'b0;
    for (int i = 0; i < NUM_LAMPS; i++) begin
      trig_d[i] = trig_q[i];
      col_d[i] = col_q[i];
    end
    // Status and held words are read only; a write there changes nothing
    if (wr_fire && mapped) begin
      if (in_lamp) begin
        if (hit_trig) begin
          trig_d[lamp_idx] = pwdata & TRIG_MASK;
        end else begin
          col_d[lamp_idx] = pwdata & COL_MASK;
        end
      end else if (hit_ctrl) begin
        ctrl_d = pwdata & CTRL_MASK;
      end else if (hit_cmd) begin
        link_ack_d = pwdata[ilm_pkg::CMD_LINK_ACK_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ctrl_q <= ilm_pkg::CTRL_RST;
      for (int i = 0; i < NUM_LAMPS; i++) begin
        trig_q[i] <= ilm_pkg::TRIG_RST;
        col_q[i] <= ilm_pkg::COL_RST;
      end
    end else begin
      ctrl_q <= ctrl_d;
      for (int i = 0; i < NUM_LAMPS; i++) begin
        trig_q[i] <= trig_d[i];
        col_q[i] <= col_d[i];
      end
    end
  end

  // Panel key passes two flops before the edge detector reads it
  always_comb begin
    key_s1_d = panel_clear_key;
    key_s2_d = key_s1_q;
    key_s3_d = key_s2_q;
    alarm_prev_d = prot_alarm;
  end

  // Acknowledgment sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_s3_q <= 1'b0;
      alarm_prev_q <= 1'b0;
      link_ack_q <= 1'b0;
    end else begin
      key_s1_q <= key_s1_d;
      key_s2_q <= key_s2_d;
      key_s3_q <= key_s3_d;
      alarm_prev_q <= alarm_prev_d;
      link_ack_q <= link_ack_d;
    end
  end

  always_comb begin
    panel_ack = key_s2_q & ~key_s3_q;
    alarm_ack = prot_alarm & ~alarm_prev_q;
    remote_ack = ctrl_q[ilm_pkg::CTRL_REMOTE_EN_BIT] & (global_lamp_clear_input | link_ack_q);
  end

  ilm_flash_gen #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .phase(phase)
  );

  for (genvar g = 0; g < NUM_LAMPS; g++) begin : g_lamp
    ilm_cfg_if cfg_if ();
    assign cfg_if.sel = trig_q[g][ilm_pkg::TRIG_SEL_LSB +: ilm_pkg::SLOTS*ilm_pkg::SEL_W];
    assign cfg_if.inv = trig_q[g][ilm_pkg::TRIG_INV_LSB +: ilm_pkg::SLOTS];
    assign cfg_if.mode = ilm_pkg::ilm_hold_t'(trig_q[g][ilm_pkg::TRIG_MODE_LSB +: 2]);

    ilm_lamp_cell u_cell (
      .pclk(pclk),
      .por_n(por_n),
      .sig(prot_sig),
      .cfg(cfg_if.lamp),
      .own_clear(lamp_clear_in[g]),
      .panel_ack(panel_ack),
      .remote_ack(remote_ack),
      .alarm_ack(alarm_ack),
      .active(active[g]),
      .held(held[g])
    );
  end

  // Colour drive per lamp
  // Codes 5 to 7 leave the lamp dark
  always_comb begin
    logic [1:0] rg;
    rg = 2'h0;
    for (int i = 0; i < NUM_LAMPS; i++) begin
      if (active[i]) begin
        rg = ilm_pkg::ilm_colour_drive(col_q[i][ilm_pkg::COL_ON_LSB +: 3], phase);
      end else begin
        rg = ilm_pkg::ilm_colour_drive(col_q[i][ilm_pkg::COL_OFF_LSB +: 3], phase);
      end
      red_d[i] = rg[1];
      green_d[i] = rg[0];
    end
  end

  // Health lamp: fixed function, not configurable
  always_comb begin
    hs_d = hs_q;
    health_d = 1'b0;
    unique case (hs_q)
      ilm_pkg::ILM_HS_BOOT: begin
        health_d = phase;
        if (boot_done) begin
          hs_d = ilm_pkg::ILM_HS_RUN;
        end
      end
      // Once running the lamp stays steady until the bus reset
      ilm_pkg::ILM_HS_RUN: begin
        health_d = 1'b1;
      end
      default: begin
        hs_d = ilm_pkg::ILM_HS_BOOT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_q <= '0;
      green_q <= '0;
      hs_q <= ilm_pkg::ILM_HS_BOOT;
      health_q <= 1'b0;
    end else begin
      red_q <= red_d;
      green_q <= green_d;
      hs_q <= hs_d;
      health_q <= health_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lamp_red = red_q;
  assign lamp_green = green_q;
  assign health_green = health_q;

endmodule

// ===== verification/ilm_prot_src.sv
`timescale 1ns/1ps
module ilm_prot_src (
  input wire logic pclk,
  input wire logic [20:0] want,
  output logic [14:0] prot_sig,
  output logic [1:0] lamp_clr,
  output logic glob_clr,
  output logic alarm,
  output logic boot,
  output logic key
);
  // Protection logic and clear sources change state just after an edge
  always_ff @(posedge pclk) begin
    {key, boot, alarm, glob_clr, lamp_clr, prot_sig} <= want;
  end
endmodule

// ===== verification/ilm_lamp_top_assertions.sv
`timescale 1ns/1ps
module ilm_lamp_top_assertions #(
  parameter int NUM_LAMPS = 8,
  parameter int unsigned FLASH_HALF_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic boot_done,
  input wire logic [NUM_LAMPS-1:0] lamp_red,
  input wire logic [NUM_LAMPS-1:0] lamp_green,
  input wire logic health_green
);
  logic hg_q;
  int unsigned run_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // Cycles the health lamp has kept its level while booting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hg_q <= 1'b0;
      run_q <= 0;
    end else begin
      hg_q <= health_green;
      run_q <= (boot_done || health_green != hg_q) ? 0 : run_q + 1;
    end
  end
  AST_PREADY_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_ACCESS: assert property (pready |-> s_access)
    else $error("pready outside access phase");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_IDLE: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside read answer");
  AST_COLOUR_EXCL: assert property ((lamp_red & lamp_green) == '0)
    else $error("lamp red and green together");
  AST_HEALTH_STEADY: assert property (boot_done [*4] |-> health_green)
    else $error("health lamp not steady after boot");
  AST_HEALTH_FLASH: assert property (run_q <= FLASH_HALF_CYC + 2)
    else $error("health lamp not flashing while booting");
endmodule
bind ilm_lamp_top ilm_lamp_top_assertions #(.NUM_LAMPS(NUM_LAMPS), .FLASH_HALF_CYC(FLASH_HALF_CYC)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .boot_done(boot_done), .lamp_red(lamp_red),
  .lamp_green(lamp_green), .health_green(health_green));

// ===== verification/test_latched_indicator_lamp_logic.sv
`timescale 1ns/1ps
module test_latched_indicator_lamp_logic;
  localparam logic [7:0] TRIG1 = ilm_pkg::OFS_LAMP_BASE + 8'h08;
  typedef struct packed {logic [31:0] trig; logic [31:0] col; logic [14:0] s; logic [3:0] r; logic [3:0] g;} ilm_row_t;
  ilm_row_t rows[6] = '{
    '{32'h0000_0001, 32'h0000_0021, 15'h0001, 4'h0, 4'h8},
    '{32'h0000_0001, 32'h0000_0021, 15'h0000, 4'h8, 4'h0},
    '{32'h000F_0000, 32'h0000_0002, 15'h4000, 4'h8, 4'h0},
    '{32'h0020_0030, 32'h0000_0013, 15'h0000, 4'h4, 4'h0},
    '{32'h0010_0000, 32'h0000_0004, 15'h7FFF, 4'h0, 4'h0},
    '{32'h0000_0001, 32'h0000_0004, 15'h0001, 4'h0, 4'h4}};
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
  logic glob, alarm, boot, key, gc, al, bd, pk, hg;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] sig, ps;
  logic [1:0] lclr, lc, red, grn;
  logic [3:0] r, g;
  int fail_count, check_count, cyc;
  ilm_prot_src i_src (.pclk(pclk), .want({key, boot, alarm, glob, lclr, sig}), .prot_sig(ps), .lamp_clr(lc),
    .glob_clr(gc), .alarm(al), .boot(bd), .key(pk));
  ilm_lamp_top #(.NUM_LAMPS(2), .FLASH_HALF_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prot_sig(ps), .lamp_clear_in(lc), .global_lamp_clear_input(gc),
    .prot_alarm(al), .boot_done(bd), .panel_clear_key(pk), .lamp_red(red), .lamp_green(grn),
    .health_green(hg));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Trigger lamp 1 for a few cycles, then leave all triggers low
  task automatic pulse();
    sig[1] <= 1'b1;
    wt(3);
    sig[1] <= 1'b0;
    wt(3);
  endtask
  task automatic held_is(input logic h, input string n);
    apb(1'b0, ilm_pkg::OFS_HELD, 32'h0);
    chk(n, {31'h0, h}, {31'h0, rd[1]});
    chk({n, " red"}, {31'h0, h}, {31'h0, red[1]});
    chk({n, " green"}, {31'h0, ~h}, {31'h0, grn[1]});
    chk({n, " err"}, 32'h0, {31'h0, err});
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    {presetn, por_n, psel, penable, pwrite, glob, alarm, boot, key} = '0;
    {paddr, pwdata, sig, lclr} = '0;
    wt(20);
    presetn <= 1'b1;
    por_n <= 1'b1;
    apb(1'b0, ilm_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", ilm_pkg::CTRL_RST, rd);
    apb(1'b0, TRIG1, 32'h0);
    chk("trig reset", ilm_pkg::TRIG_RST, rd);
    foreach (rows[i]) begin
      apb(1'b1, ilm_pkg::OFS_LAMP_BASE, rows[i].trig);
      apb(1'b1, ilm_pkg::OFS_LAMP_BASE + 8'h04, rows[i].col);
      sig <= rows[i].s;
      wt(4);
      {r, g} = '0;
      repeat (8) begin
        @(posedge pclk);
        r = r + red[0];
        g = g + grn[0];
      end
      chk("lamp0 red count", {28'h0, rows[i].r}, {28'h0, r});
      chk("lamp0 green count", {28'h0, rows[i].g}, {28'h0, g});
    end
    sig <= '0;
    boot <= 1'b1;
    apb(1'b1, TRIG1, 32'h0200_0002);
    apb(1'b1, TRIG1 + 8'h04, 32'h0000_0012);
    apb(1'b0, TRIG1 + 8'h04, 32'h0);
    chk("colour readback", 32'h0000_0012, rd);
    chk("health steady", 32'h1, {31'h0, hg});
    pulse();
    held_is(1'b1, "hold");
    apb(1'b0, ilm_pkg::OFS_STATUS, 32'h0);
    chk("status held", 32'h0000_0002, rd);
    sig[1] <= 1'b1;
    lclr[1] <= 1'b1;
    wt(3);
    lclr[1] <= 1'b0;
    wt(2);
    sig[1] <= 1'b0;
    wt(3);
    held_is(1'b1, "clear while active");
    lclr[1] <= 1'b1;
    wt(3);
    lclr[1] <= 1'b0;
    held_is(1'b0, "own clear");
    pulse();
    glob <= 1'b1;
    wt(3);
    glob <= 1'b0;
    apb(1'b1, ilm_pkg::OFS_CMD, 32'h1);
    held_is(1'b1, "remote gated");
    apb(1'b1, ilm_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, ilm_pkg::OFS_CMD, 32'h1);
    held_is(1'b0, "link ack");
    pulse();
    glob <= 1'b1;
    wt(3);
    glob <= 1'b0;
    held_is(1'b0, "global ack");
    pulse();
    key <= 1'b1;
    wt(6);
    key <= 1'b0;
    held_is(1'b0, "panel key");
    apb(1'b1, TRIG1, 32'h0400_0002);
    pulse();
    alarm <= 1'b1;
    wt(3);
    alarm <= 1'b0;
    held_is(1'b0, "alarm ack");
    pulse();
    presetn <= 1'b0;
    wt(3);
    presetn <= 1'b1;
    wt(2);
    held_is(1'b1, "restart");
    apb(1'b1, TRIG1, 32'h0000_0002);
    held_is(1'b0, "hold off");
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    conclude();
  end
endmodule
